// ---- hw/tpgm_timer.sv ----
// Behaviour
// - single drives one pin, dual adds complement
// - pwm output toggles when count equals match
// - at reload interrupt, count restarts at 0001h
// - pwm output starts at polarity, resets at reload
// - dual outputs delay rising edges by deadband
// - loaded start count only shapes first pass
// - high time follows match, reload and polarity
// - capture edge copies count into pwm register
// - flag set on capture, cleared on reload
// - config picks capture, reload or both interrupts
// - input synchronised, capture two-three clocks late
// - capture modes toggle enabled output at reload
// - capture mode wraps, never resets count
// - capture restart resets on capture or reload
// - capture compare waits for first input edge
// - compare interrupts and toggles without reset
// - gated counts only while input active
// - gated interrupts on deassert, reload or both
// - gated reload restarts count and toggles output
// - mode is four bits split over two fields
module tpgm_timer #(
  parameter int CNT_W = tpgm_pkg::CNT_W
) (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // control fields
  input wire logic enable,
  input wire logic mode_select_field_hi,
  input wire logic [2:0] mode_select_field_lo,
  input wire logic [tpgm_pkg::PRESCALE_W-1:0] prescale,
  input wire logic output_polarity_bit,
  input wire logic output_function_en,
  input wire logic [tpgm_pkg::DEAD_W-1:0] deadband_delay_field,
  input wire logic [1:0] interrupt_source_config,
  // software loads of count, pwm value and reload
  input wire logic count_load,
  input wire logic [CNT_W-1:0] count_load_value,
  input wire logic pwm_load,
  input wire logic [CNT_W-1:0] pwm_load_value,
  input wire logic reload_load,
  input wire logic [CNT_W-1:0] reload_load_value,
  // timer pins
  input wire logic timer_in,
  output logic timer_out,
  output logic timer_out_n,
  // status
  output logic [CNT_W-1:0] count,
  output logic [CNT_W-1:0] pwm_value,
  output logic [CNT_W-1:0] reload_value,
  output logic capture_source_flag,
  output logic running,
  output logic timer_irq
);

  tpgm_pkg::tpgm_state_e state;
  tpgm_pkg::tpgm_state_e next_state;
  logic [tpgm_pkg::PRE_W-1:0] pre;
  logic out_level;

  // width check: the reset constants are sixteen bits wide
  initial begin
    if (CNT_W != tpgm_pkg::CNT_W) begin
      $error("tpgm_timer supports only a sixteen bit counter");
    end
  end

  // mode decode
  logic [3:0] mode;
  logic is_pwm;
  logic is_dual;
  logic is_cap;
  logic is_caprs;
  logic is_capcmp;
  logic is_cmp;
  logic is_gated;
  logic is_capture_class;
  logic is_restart_class;
  logic supported;

  assign mode = {mode_select_field_hi, mode_select_field_lo};
  assign is_dual = mode == tpgm_pkg::MODE_PWM_DUAL;
  assign is_pwm = is_dual || mode == tpgm_pkg::MODE_PWM_SINGLE;
  assign is_cap = mode == tpgm_pkg::MODE_CAPTURE;
  assign is_caprs = mode == tpgm_pkg::MODE_CAP_RESTART;
  assign is_capcmp = mode == tpgm_pkg::MODE_CAP_CMP;
  assign is_cmp = mode == tpgm_pkg::MODE_COMPARE;
  assign is_gated = mode == tpgm_pkg::MODE_GATED;
  assign is_capture_class = is_cap || is_caprs || is_capcmp;
  assign is_restart_class = is_pwm || is_caprs || is_capcmp || is_gated;
  assign supported = is_pwm || is_capture_class || is_cmp || is_gated;

  // timer input, synchronised before any use
  logic in_level;
  logic in_rise;
  logic in_fall;

  tpgm_sync_edge #(
    .STAGES(tpgm_pkg::SYNC_STAGES)
  ) u_sync (
    .clock(clock),
    .nrst(nrst),
    .pin(timer_in),
    .level(in_level),
    .rise(in_rise),
    .fall(in_fall)
  );

  // input qualification by polarity
  logic in_active;
  logic cap_edge;
  logic gate_drop;

  assign in_active = in_level == output_polarity_bit;
  assign cap_edge = output_polarity_bit ? in_rise : in_fall;
  assign gate_drop = output_polarity_bit ? in_fall : in_rise;

  // prescaler tick; mask of low bits set gives divide by 2^prescale
  logic [tpgm_pkg::PRE_W-1:0] pre_mask;
  logic run;
  logic tick;

  assign pre_mask = tpgm_pkg::PRE_W'((tpgm_pkg::PRE_ONE << prescale)
                                     - tpgm_pkg::PRE_ONE);
  assign run = state == tpgm_pkg::tpgm_run;
  assign tick = run && ((pre & pre_mask) == pre_mask);

  // counting events
  logic advance;
  logic reload_evt;
  logic match_evt;
  logic cap_evt;
  logic first_edge;
  logic drop_evt;
  logic restart;

  assign advance = tick && supported && (!is_gated || in_active);
  assign reload_evt = advance && count == reload_value;
  assign match_evt = is_pwm && advance && count == pwm_value;
  assign cap_evt = run && is_capture_class && cap_edge;
  assign first_edge = state == tpgm_pkg::tpgm_wait && cap_edge;
  assign drop_evt = run && is_gated && gate_drop;
  // plain capture and compare keep counting through reload
  assign restart = (is_restart_class && reload_evt)
                   || ((is_caprs || is_capcmp) && cap_evt);

  // interrupt source selection
  logic cap_irq_ok;
  logic rel_irq_ok;
  logic raise_cap;
  logic raise_rel;

  assign cap_irq_ok = interrupt_source_config != tpgm_pkg::ICFG_RELOAD_ONLY;
  assign rel_irq_ok = interrupt_source_config != tpgm_pkg::ICFG_CAPTURE_ONLY;
  assign raise_cap = (cap_evt || drop_evt) && cap_irq_ok;
  assign raise_rel = reload_evt && rel_irq_ok;

  // next count: software load first, then restart, then advance
  logic [CNT_W-1:0] next_count;

  assign next_count = count_load ? count_load_value
                    : restart ? tpgm_pkg::COUNT_RESTART
                    : advance ? count + tpgm_pkg::COUNT_STEP
                    : count;

  // next output level; pwm forces polarity at reload
  logic toggle_en;
  logic next_out_level;

  assign toggle_en = output_function_en && reload_evt
                     && (is_capture_class || is_cmp || is_gated);
  assign next_out_level = !run && state != tpgm_pkg::tpgm_wait
                          ? output_polarity_bit
                        : is_pwm && reload_evt ? output_polarity_bit
                        : match_evt ? ~out_level
                        : toggle_en ? ~out_level
                        : out_level;

  // run state: capture compare parks until the first edge
  always_comb begin
    next_state = state;
    case (state)
      tpgm_pkg::tpgm_off: begin
        if (enable) begin
          next_state = is_capcmp ? tpgm_pkg::tpgm_wait
                                 : tpgm_pkg::tpgm_run;
        end
      end
      tpgm_pkg::tpgm_wait: begin
        if (!enable) begin
          next_state = tpgm_pkg::tpgm_off;
        end else if (first_edge) begin
          next_state = tpgm_pkg::tpgm_run;
        end
      end
      tpgm_pkg::tpgm_run: begin
        if (!enable) begin
          next_state = tpgm_pkg::tpgm_off;
        end
      end
      default: begin
        next_state = tpgm_pkg::tpgm_off;
      end
    endcase
  end

  // state and prescaler; prescaler restarts whenever the state is not run, but keeps running while a gated input is inactive
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state <= tpgm_pkg::tpgm_off;
      pre <= tpgm_pkg::PRE_RESET;
    end else begin
      state <= next_state;
      pre <= run ? pre + tpgm_pkg::PRE_STEP : tpgm_pkg::PRE_RESET;
    end
  end

  // counter
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      count <= tpgm_pkg::COUNT_RESET;
    end else begin
      count <= next_count;
    end
  end

  // pwm value doubles as capture register; capture beats software
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pwm_value <= tpgm_pkg::PWM_RESET;
    end else if (cap_evt) begin
      pwm_value <= count;
    end else if (pwm_load) begin
      pwm_value <= pwm_load_value;
    end
  end

  // reload value, written whole so no torn update reaches the compare
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      reload_value <= tpgm_pkg::RELOAD_RESET;
    end else if (reload_load) begin
      reload_value <= reload_load_value;
    end
  end

  // interrupt pulse and source flag; a capture wins a tie
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      timer_irq <= 1'b0;
      capture_source_flag <= 1'b0;
    end else begin
      timer_irq <= raise_cap || raise_rel;
      if (raise_cap) begin
        capture_source_flag <= 1'b1;
      end else if (raise_rel) begin
        capture_source_flag <= 1'b0;
      end
    end
  end

  // output level register
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      out_level <= 1'b0;
    end else begin
      out_level <= next_out_level;
    end
  end

  // deadband pair, used only in dual output
  logic db_p;
  logic db_n;

  tpgm_deadband u_dead (
    .clock(clock),
    .nrst(nrst),
    .level(out_level),
    .dead(deadband_delay_field),
    .out_p(db_p),
    .out_n(db_n)
  );

  // pin outputs; the complement pin idles low outside dual mode
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      timer_out <= 1'b0;
      timer_out_n <= 1'b0;
    end else begin
      timer_out <= is_dual ? db_p : out_level;
      timer_out_n <= is_dual & db_n;
    end
  end

  assign running = run;

endmodule // tpgm_timer

// ---- hw/tpgm_pkg.sv ----
package tpgm_pkg;

  // counter geometry and restart values
  localparam int CNT_W = 16;
  localparam logic [15:0] COUNT_RESTART = 16'h0001;
  localparam logic [15:0] COUNT_RESET = 16'h0001;
  localparam logic [15:0] RELOAD_RESET = 16'hffff;
  localparam logic [15:0] PWM_RESET = 16'h0000;
  localparam logic [15:0] COUNT_STEP = 16'h0001;

  // operating mode codes, four bits wide
  localparam logic [3:0] MODE_PWM_SINGLE = 4'h3;
  localparam logic [3:0] MODE_CAPTURE = 4'h4;
  localparam logic [3:0] MODE_COMPARE = 4'h5;
  localparam logic [3:0] MODE_GATED = 4'h6;
  localparam logic [3:0] MODE_CAP_CMP = 4'h7;
  localparam logic [3:0] MODE_PWM_DUAL = 4'h8;
  localparam logic [3:0] MODE_CAP_RESTART = 4'h9;

  // interrupt source selection
  localparam logic [1:0] ICFG_CAPTURE_ONLY = 2'h2;
  localparam logic [1:0] ICFG_RELOAD_ONLY = 2'h3;

  // prescaler: divide by two to the power of the setting
  localparam int PRE_W = 7;
  localparam int PRESCALE_W = 3;
  localparam logic [7:0] PRE_ONE = 8'h01;
  localparam logic [6:0] PRE_RESET = 7'h00;
  localparam logic [6:0] PRE_STEP = 7'h01;

  // deadband limit in system clocks
  localparam int DEAD_W = 8;
  localparam logic [7:0] DEAD_MAX = 8'h80;
  localparam logic [7:0] DEAD_STEP = 8'h01;

  // input synchroniser depth
  localparam int SYNC_STAGES = 2;

  // run state of the counter
  typedef enum logic [1:0] {
    tpgm_off,
    tpgm_wait,
    tpgm_run
  } tpgm_state_e;

endpackage

// ---- hw/tpgm_sync_edge.sv ----
// input synchroniser with edge detect behind the last stage
module tpgm_sync_edge #(
  parameter int STAGES = tpgm_pkg::SYNC_STAGES
) (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // raw pin
  input wire logic pin,
  // synchronised level and edges
  output logic level,
  output logic rise,
  output logic fall
);

  logic [STAGES-1:0] stage;
  logic prev;

  // the first flop only feeds the next flop; edges come from later ones
  initial begin
    if (STAGES < 2) begin
      $error("tpgm_sync_edge needs at least two stages");
    end
  end

  // shift chain, one flop per stage
  genvar i;
  generate
    for (i = 0; i < STAGES; i++) begin : g_stage
      always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
          stage[i] <= 1'b0;
        end else begin
          stage[i] <= (i == 0) ? pin : stage[(i == 0) ? 0 : i - 1];
        end
      end
    end
  endgenerate

  // delayed copy for edge detection
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      prev <= 1'b0;
    end else begin
      prev <= stage[STAGES-1];
    end
  end

  assign level = stage[STAGES-1];
  assign rise = stage[STAGES-1] & ~prev;
  assign fall = ~stage[STAGES-1] & prev;

endmodule // tpgm_sync_edge

// ---- hw/tpgm_deadband.sv ----
// complementary pair whose rising edges wait out a deadband
module tpgm_deadband (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // requested level and delay
  input wire logic level,
  input wire logic [tpgm_pkg::DEAD_W-1:0] dead,
  // driven pair
  output logic out_p,
  output logic out_n
);

  logic [tpgm_pkg::DEAD_W-1:0] wait_cnt;
  logic last;
  logic [tpgm_pkg::DEAD_W-1:0] dead_lim;
  logic changed;
  logic settled;
  logic dead_zero;

  // values above the limit are clipped rather than wrapping
  assign dead_lim = (dead > tpgm_pkg::DEAD_MAX) ? tpgm_pkg::DEAD_MAX : dead;
  assign changed = level != last;
  assign settled = !changed && wait_cnt == '0;
  // zero gap lets the rising side follow in the same cycle as the fall
  assign dead_zero = dead_lim == '0;

  // countdown restarts on every change of the requested level
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wait_cnt <= '0;
      last <= 1'b0;
    end else begin
      last <= level;
      if (changed) begin
        // the change cycle itself is the first clock of the gap
        wait_cnt <= dead_zero ? '0 : dead_lim - tpgm_pkg::DEAD_STEP;
      end else if (wait_cnt != '0) begin
        wait_cnt <= wait_cnt - tpgm_pkg::DEAD_STEP;
      end
    end
  end

  // falling edges are immediate, rising edges wait for the gap
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      out_p <= 1'b0;
      out_n <= 1'b0;
    end else begin
      out_p <= level & (changed ? dead_zero : (settled | out_p));
      out_n <= ~level & (changed ? dead_zero : (settled | out_n));
    end
  end

endmodule // tpgm_deadband

// ---- bench/tpgm_timer_assertions.sv ----
module tpgm_timer_assertions #(
  parameter int CNT_W = 16
) (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // control fields
  input wire logic enable,
  input wire logic mode_select_field_hi,
  input wire logic [2:0] mode_select_field_lo,
  input wire logic [tpgm_pkg::PRESCALE_W-1:0] prescale,
  input wire logic output_polarity_bit,
  input wire logic output_function_en,
  input wire logic [tpgm_pkg::DEAD_W-1:0] deadband_delay_field,
  input wire logic [1:0] interrupt_source_config,
  input wire logic count_load,
  input wire logic [CNT_W-1:0] count_load_value,
  // pins and status
  input wire logic timer_in,
  input wire logic timer_out,
  input wire logic timer_out_n,
  input wire logic [CNT_W-1:0] count,
  input wire logic [CNT_W-1:0] pwm_value,
  input wire logic [CNT_W-1:0] reload_value,
  input wire logic capture_source_flag,
  input wire logic running,
  input wire logic timer_irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  logic [3:0] md;
  logic [7:0] lo_cnt;
  logic p0, pwm, cap, unsup;
  // mode decode; p0 means one count per clock
  assign md = {mode_select_field_hi, mode_select_field_lo};
  assign p0 = enable && running && prescale == 3'h0;
  assign pwm = md == tpgm_pkg::MODE_PWM_SINGLE || md == tpgm_pkg::MODE_PWM_DUAL;
  assign cap = md == tpgm_pkg::MODE_CAPTURE || md == tpgm_pkg::MODE_CAP_RESTART;
  assign unsup = md < 4'h3 || md > 4'h9;
  // gap length with both outputs low, saturating
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) lo_cnt <= 8'h00;
    else if (timer_out || timer_out_n) lo_cnt <= 8'h00;
    else if (lo_cnt != 8'hff) lo_cnt <= lo_cnt + 8'h01;
  end
  AST_LOAD: assert property (
    count_load |=> count == $past(count_load_value))
    else $error("count load not taken");
  AST_PWM_RELOAD: assert property (
    pwm && p0 && count == reload_value && !count_load &&
    interrupt_source_config != tpgm_pkg::ICFG_CAPTURE_ONLY
    |=> count == tpgm_pkg::COUNT_RESTART && timer_irq)
    else $error("pwm reload did not restart");
  AST_CAP_COPY: assert property (
    cap && enable && (output_polarity_bit ? $rose(timer_in) : $fell(timer_in))
    |-> ##3 pwm_value == $past(count))
    else $error("capture value wrong");
  AST_CAP_IRQ: assert property (
    cap && enable && (output_polarity_bit ? $rose(timer_in) : $fell(timer_in))
    && interrupt_source_config == tpgm_pkg::ICFG_CAPTURE_ONLY
    |-> ##3 timer_irq && capture_source_flag)
    else $error("capture irq missing");
  AST_WRAP: assert property (
    md == tpgm_pkg::MODE_CAPTURE && p0 && count == 16'hffff && !count_load
    |=> count == 16'h0000)
    else $error("capture count did not wrap");
  AST_COMPARE: assert property (
    md == tpgm_pkg::MODE_COMPARE && p0 && output_function_en &&
    count == reload_value && !count_load
    |=> count == $past(count) + 16'h0001 ##1 timer_out != $past(timer_out))
    else $error("compare match misbehaved");
  AST_GATE_HOLD: assert property (
    (md == tpgm_pkg::MODE_GATED && !count_load &&
    timer_in != output_polarity_bit) [*5] |=> $stable(count))
    else $error("gated counter moved while inactive");
  AST_DEADBAND: assert property (
    md == tpgm_pkg::MODE_PWM_DUAL && ($rose(timer_out) || $rose(timer_out_n))
    |-> lo_cnt >= deadband_delay_field)
    else $error("deadband gap too short");
  AST_UNSUP: assert property (
    unsup && !count_load |=> $stable(count) && !timer_irq)
    else $error("unsupported mode changed count");
  // main scenarios reached
  cover property (pwm && timer_irq);
  cover property (md == tpgm_pkg::MODE_GATED && timer_irq);
  cover property (md == tpgm_pkg::MODE_PWM_DUAL && timer_out_n);
endmodule // tpgm_timer_assertions

// ---- bench/tpgm_pin_model.sv ----
module tpgm_pin_model (
  // clock
  input wire logic clock,
  // requested input level and its lag in cycles
  input wire logic want,
  input wire logic [3:0] lag,
  // timer pins
  output logic timer_in,
  input wire logic timer_out,
  // measured high time of the output
  output logic [15:0] hi_len
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_cnt = 4'h0;
  logic [15:0] hi_run = 16'h0000;
  initial timer_in = 1'b0;
  initial hi_len = 16'h0000;
  // a slow source holds the old level for lag cycles
  always @(posedge clock) begin
    if (want == timer_in) wait_cnt <= 4'h0;
    else if (wait_cnt >= lag) timer_in <= want;
    else wait_cnt <= wait_cnt + 4'h1;
  end
  // load side latches each finished high pulse
  always @(posedge clock) begin
    hi_run <= timer_out ? hi_run + 16'h0001 : 16'h0000;
    if (!timer_out && hi_run != 16'h0000) hi_len <= hi_run;
  end
endmodule // tpgm_pin_model

// ---- bench/test_timer_pwm_capture_gated_modes.sv ----
module test_timer_pwm_capture_gated_modes;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic enable = 1'b0;
  logic mode_select_field_hi = 1'b0; // idle code, no pair out of reset
  logic [2:0] mode_select_field_lo = 3'h0;
  logic [2:0] prescale = 3'h0;
  logic output_polarity_bit = 1'b0;
  logic output_function_en = 1'b1;
  logic [7:0] deadband_delay_field = 8'h03;
  logic [1:0] interrupt_source_config = 2'h0;
  logic count_load = 1'b0, pwm_load = 1'b0, reload_load = 1'b0;
  logic [15:0] count_load_value = 16'h0001;
  logic [15:0] pwm_load_value = 16'h0000;
  logic [15:0] reload_load_value = 16'hffff;
  logic timer_in, timer_out, timer_out_n, capture_source_flag, running;
  logic timer_irq;
  logic [15:0] count, pwm_value, reload_value, hi_len, snap;
  logic want = 1'b0;
  logic [3:0] lag = 4'h0;
  int err_total = 0;
  int compares = 0;
  tpgm_timer uut (.*);
  tpgm_pin_model partner (.clock(clock), .want(want), .lag(lag),
    .timer_in(timer_in), .timer_out(timer_out), .hi_len(hi_len));
  always #10 clock = ~clock;
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic pin(input logic v);
    @(posedge clock);
    want <= v;
  endtask
  // disable, configure and load, then enable last
  task automatic setup(input logic [3:0] md, input logic pol,
      input logic [2:0] pre, input logic [1:0] ic, input logic [15:0] st,
      input logic [15:0] mt, input logic [15:0] rl);
    @(posedge clock);
    enable <= 1'b0;
    @(posedge clock);
    {mode_select_field_hi, mode_select_field_lo} <= md;
    output_polarity_bit <= pol;
    prescale <= pre;
    interrupt_source_config <= ic;
    {count_load, pwm_load, reload_load} <= 3'h7;
    count_load_value <= st;
    pwm_load_value <= mt;
    reload_load_value <= rl;
    @(posedge clock);
    {count_load, pwm_load, reload_load} <= 3'h0;
    enable <= 1'b1;
    #1;
  endtask
  // irq is a one-cycle pulse, so look after every edge
  task automatic wait_irq(input int n);
    int i;
    i = 0;
    do begin
      @(posedge clock);
      #1;
      i++;
    end while (timer_irq !== 1'b1 && i < n);
    check({15'h0, timer_irq}, 16'h0001);
  endtask
  initial begin
    repeat (8) @(posedge clock);
    nrst <= 1'b1;
    #1;
    check(count, 16'h0001);
    check(reload_value, 16'hffff);
    check(pwm_value, 16'h0000);
    // dual first: high time shrinks by the deadband
    setup(tpgm_pkg::MODE_PWM_DUAL, 1'b0, 3'h0, 2'h0, 16'h1, 16'h4, 16'h10);
    step(40);
    check(hi_len, 16'h0009);
    // single with a late start count, then both polarities
    setup(tpgm_pkg::MODE_PWM_SINGLE, 1'b0, 3'h0, 2'h0, 16'h6, 16'h3, 16'h8);
    wait_irq(6);
    check(count, 16'h0001);
    step(40);
    check(hi_len, 16'h0005);
    check({15'h0, timer_out_n}, 16'h0000);
    setup(tpgm_pkg::MODE_PWM_SINGLE, 1'b1, 3'h0, 2'h0, 16'h1, 16'h3, 16'h8);
    step(40);
    check(hi_len, 16'h0003);
    // plain capture on a rising edge, then a reload across the wrap
    setup(tpgm_pkg::MODE_CAPTURE, 1'b1, 3'h0, tpgm_pkg::ICFG_CAPTURE_ONLY,
      16'h1, 16'h0, 16'hffff);
    step(20);
    pin(1'b1);
    wait_irq(8);
    check({15'h0, capture_source_flag}, 16'h0001);
    setup(tpgm_pkg::MODE_CAPTURE, 1'b1, 3'h0, 2'h0, 16'hfff0, 16'h0, 16'h20);
    wait_irq(64);
    check({15'h0, capture_source_flag}, 16'h0000);
    check(count, 16'h0021);
    // restart on a falling edge from a slow source
    lag <= 4'h5;
    setup(tpgm_pkg::MODE_CAP_RESTART, 1'b0, 3'h0,
      tpgm_pkg::ICFG_CAPTURE_ONLY, 16'h1, 16'h0, 16'hffff);
    step(10);
    pin(1'b0);
    wait_irq(16);
    check(count, 16'h0001);
    // capture/compare idles until the first transition
    setup(tpgm_pkg::MODE_CAP_CMP, 1'b1, 3'h0, tpgm_pkg::ICFG_CAPTURE_ONLY,
      16'h1, 16'h0, 16'hffff);
    step(10);
    check({15'h0, running}, 16'h0000);
    pin(1'b1);
    step(12);
    check({15'h0, running}, 16'h0001);
    pin(1'b0);
    step(10);
    pin(1'b1);
    wait_irq(16);
    check(count, 16'h0001);
    // compare keeps counting past the match
    setup(tpgm_pkg::MODE_COMPARE, 1'b0, 3'h0, tpgm_pkg::ICFG_RELOAD_ONLY,
      16'h1, 16'h0, 16'ha);
    wait_irq(14);
    check(count, 16'h000b);
    // divide by four: ten steps in forty clocks
    setup(tpgm_pkg::MODE_COMPARE, 1'b0, 3'h2, 2'h0, 16'h1, 16'h0, 16'hffff);
    step(10);
    snap = count;
    step(40);
    check(count - snap, 16'h000a);
    // gated: frozen while inactive, irq on deassert
    lag <= 4'h0;
    pin(1'b0);
    setup(tpgm_pkg::MODE_GATED, 1'b1, 3'h0, tpgm_pkg::ICFG_CAPTURE_ONLY,
      16'h1, 16'h0, 16'hffff);
    step(10);
    check(count, 16'h0001);
    pin(1'b1);
    step(20);
    pin(1'b0);
    wait_irq(8);
    check({15'h0, capture_source_flag}, 16'h0001);
    // unsupported code holds the count
    setup(4'h0, 1'b0, 3'h0, 2'h0, 16'h55, 16'h0, 16'h10);
    step(10);
    check(count, 16'h0055);
    print_verdict;
  end
  // watchdog well beyond the expected run length
  initial begin
    #100us;
    err_total++;
    print_verdict;
  end
endmodule // test_timer_pwm_capture_gated_modes

bind tpgm_timer tpgm_timer_assertions #(.CNT_W(CNT_W)) u_chk (.*);
